// >>> rtl/pac_regs.vh
`ifndef PAC_REGS_VH
`define PAC_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PAC_ADDR_CTRL     8'h00
`define PAC_ADDR_AMOUNT   8'h04
`define PAC_ADDR_BLOCK    8'h08
`define PAC_ADDR_MCOUNT   8'h0c
`define PAC_ADDR_STATUS   8'h10
`define PAC_ADDR_CMD      8'h14
`define PAC_ADDR_PRESAMP  8'h18

// ----------------------------------------------------------------------------
// Control fields and codes
// ----------------------------------------------------------------------------
`define PAC_CTL_EN        1:0
`define PAC_CTL_BLK       2
`define PAC_CTL_SRC       3
`define PAC_CTL_POL       4
`define PAC_CTL_ARM       6:5
`define PAC_CTL_DLY       8:7
`define PAC_CTL_FN        11:9
`define PAC_CTL_SUM       13:12
`define PAC_CTL_CYCLE_SAMPLING_ARM      14
`define PAC_CTL_CGATE     15
`define PAC_CTL_RESET     16'h0000
`define PAC_AMT_UNIT      31
`define PAC_AMT_VAL       15:0
`define PAC_AMT_RESET     32'h80000032
`define PAC_BLOCK_RESET   16'h0064
`define PAC_MCOUNT_RESET  16'h0064
`define PAC_CMD_START     0
`define PAC_CMD_ABORT     1
`define PAC_CMD_CLR_ERR   2
`define PAC_EN_OFF        2'h0
`define PAC_EN_ON         2'h1
`define PAC_EN_COND       2'h2
`define PAC_SRC_A         2'h0
`define PAC_SRC_B         2'h1
`define PAC_SRC_EXT       2'h2
`define PAC_DLY_OSC       2'h2
`define PAC_FN_FREQ       3'h0
`define PAC_FN_PERIOD     3'h1
`define PAC_FN_TOTAL      3'h2
`define PAC_FN_HTI        3'h3
`define PAC_FN_HCI        3'h4
`define PAC_FN_HSI        3'h5
`define PAC_SUM_NONE      2'h0
`define PAC_SUM_AB        2'h1
`define PAC_PCT_FULL      16'h0064

`endif

// >>> rtl/pac_edge_sel.v
`include "pac_regs.vh"

module pac_edge_sel (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire [1:0] sel,
  input  wire       neg,
  input  wire       arm_source_select_a,
  input  wire       arm_source_select_b,
  input  wire       ext_arm,
  output wire       edge_hit
);

  reg  lvl_q;
  reg  src;

  always @* begin
    case (sel)
      `PAC_SRC_A: src = arm_source_select_a;
      `PAC_SRC_B: src = arm_source_select_b;
      default:    src = ext_arm;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= src;
    end
  end

  // Polarity only chooses which transition counts as the event.
  assign edge_hit = neg ? (lvl_q & ~src) : (~lvl_q & src);

endmodule // pac_edge_sel

// >>> rtl/pac_pct_conv.v
`include "pac_regs.vh"

module pac_pct_conv (
  input  wire [15:0] amount,
  input  wire        unit_pct,
  input  wire [15:0] block,
  output reg  [15:0] samples
);

  reg [15:0] pct;
  reg [31:0] prod;
  reg [31:0] quot;

  // Percent above full scale is clamped, so the result never exceeds block.
  always @* begin
    pct  = (amount > `PAC_PCT_FULL) ? `PAC_PCT_FULL : amount;
    prod = pct * block;
    quot = prod / {16'h0000, `PAC_PCT_FULL};
    if (unit_pct) begin
      samples = quot[15:0];
    end else begin
      samples = (amount > block) ? block : amount;
    end
  end

endmodule // pac_pct_conv

// >>> rtl/pac_top.v
`include "pac_regs.vh"

module pac_top (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        arm_source_select_a,
  input  wire        arm_source_select_b,
  input  wire        ext_arm,
  input  wire        osc_tick,
  input  wire        ti_detect,
  input  wire        block_arm,
  input  wire        sample_tick,
  output reg         acquire,
  output reg         pretrig_hit,
  output reg         meas_done,
  output reg         block_rearm,
  output reg         sample_arm,
  output reg         stop_arm,
  output reg         delayed_arm,
  output reg  [1:0]  sum_pair
);

// ----------------------------------------------------------------------------
// States and helpers
// ----------------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ARM   = 3'h1;
  localparam [2:0] ST_WATCH = 3'h2;
  localparam [2:0] ST_POST  = 3'h3;
  localparam [2:0] ST_DONE  = 3'h4;

  function is_hist;
    input [2:0] fn;
    begin
      is_hist = (fn == `PAC_FN_HTI) || (fn == `PAC_FN_HCI) ||
                (fn == `PAC_FN_HSI);
    end
  endfunction

  // A control word that names an impossible combination is refused whole.
  function ctrl_ok;
    input [15:0] c;
    reg          bad;
    begin
      bad = 1'b0;
      if (c[`PAC_CTL_EN] == 2'h3) bad = 1'b1;
      if (c[`PAC_CTL_ARM] == 2'h3) bad = 1'b1;
      if (c[`PAC_CTL_DLY] == 2'h3) bad = 1'b1;
      if (c[`PAC_CTL_FN] > `PAC_FN_HSI) bad = 1'b1;
      if (c[`PAC_CTL_DLY] == `PAC_DLY_OSC && !c[`PAC_CTL_CYCLE_SAMPLING_ARM])
        bad = 1'b1;
      if (c[`PAC_CTL_EN] == `PAC_EN_COND && !is_hist(c[`PAC_CTL_FN]))
        bad = 1'b1;
      if (c[`PAC_CTL_SUM] != `PAC_SUM_NONE && is_hist(c[`PAC_CTL_FN]))
        bad = 1'b1;
      if (c[`PAC_CTL_FN] == `PAC_FN_TOTAL &&
          c[`PAC_CTL_SUM] != `PAC_SUM_NONE &&
          c[`PAC_CTL_SUM] != `PAC_SUM_AB)
        bad = 1'b1;
      ctrl_ok = ~bad;
    end
  endfunction

// ----------------------------------------------------------------------------
// Register state
// ----------------------------------------------------------------------------
  reg  [15:0] ctrl_q;
  reg  [31:0] amount_q;
  reg  [15:0] block_q;
  reg  [15:0] mcount_q;
  reg         err_q;
  reg         trig_seen_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [15:0] cnt_q;
  reg  [15:0] cnt_d;
  reg  [15:0] tgt_q;
  reg  [15:0] tgt_d;
  reg  [15:0] mcnt_q;
  reg  [15:0] mcnt_d;
  reg  [15:0] pre_q;

  wire        wb_req;
  wire        wr_en;
  wire        rd_en;
  wire        start_cmd;
  wire        abort_cmd;
  wire        clr_err;
  wire [15:0] pre_sample_arm_level;
  wire        ext_edge;
  wire        arm_edge;
  wire        trig_ev;
  wire [1:0]  pretrig_enable;
  wire        pretrig_block_control;
  wire        pretrig_source_select;
  wire        ext_arm_edge_polarity;
  wire [1:0]  arm_source_select;
  wire [1:0]  delayed_arm_source;
  wire [2:0]  meas_func;
  wire        cycle_sampling_arm;
  wire        cont_gating;
  wire        pretrig_unit_query;
  wire        hist_fn;
  wire [31:0] status_word;

  assign pretrig_enable        = ctrl_q[`PAC_CTL_EN];
  assign pretrig_block_control = ctrl_q[`PAC_CTL_BLK];
  assign pretrig_source_select = ctrl_q[`PAC_CTL_SRC];
  assign ext_arm_edge_polarity = ctrl_q[`PAC_CTL_POL];
  assign arm_source_select     = ctrl_q[`PAC_CTL_ARM];
  assign delayed_arm_source    = ctrl_q[`PAC_CTL_DLY];
  assign meas_func             = ctrl_q[`PAC_CTL_FN];
  assign cycle_sampling_arm    = ctrl_q[`PAC_CTL_CYCLE_SAMPLING_ARM];
  assign cont_gating           = ctrl_q[`PAC_CTL_CGATE];
  assign pretrig_unit_query    = amount_q[`PAC_AMT_UNIT];
  assign hist_fn               = is_hist(meas_func);

// ----------------------------------------------------------------------------
// Wishbone slave: one wait state, ack for one cycle
// ----------------------------------------------------------------------------
  assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en     = wb_req & wb_we_i;
  assign rd_en     = wb_req & ~wb_we_i;
  assign start_cmd = wr_en && wb_adr_i == `PAC_ADDR_CMD && wb_sel_i[0] &&
                     wb_dat_i[`PAC_CMD_START];
  assign abort_cmd = wr_en && wb_adr_i == `PAC_ADDR_CMD && wb_sel_i[0] &&
                     wb_dat_i[`PAC_CMD_ABORT];
  assign clr_err   = wr_en && wb_adr_i == `PAC_ADDR_CMD && wb_sel_i[0] &&
                     wb_dat_i[`PAC_CMD_CLR_ERR];

  assign status_word = {22'h0, mcnt_q == 16'h0000 ? 1'b0 : 1'b1,
                        state_q, err_q,
                        pretrig_source_select,
                        pretrig_unit_query,
                        trig_seen_q,
                        state_q == ST_DONE,
                        acquire};

  // Byte lanes are merged so a partial write keeps the untouched bytes.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q   <= `PAC_CTL_RESET;
      amount_q <= `PAC_AMT_RESET;
      block_q  <= `PAC_BLOCK_RESET;
      mcount_q <= `PAC_MCOUNT_RESET;
    end else if (wr_en) begin
      case (wb_adr_i)
        `PAC_ADDR_CTRL: begin
          if (ctrl_ok({wb_sel_i[1] ? wb_dat_i[15:8] : ctrl_q[15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_q[7:0]})) begin
            if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ctrl_q[15:8] <= wb_dat_i[15:8];
          end
        end
        `PAC_ADDR_AMOUNT: begin
          if (wb_sel_i[0]) amount_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) amount_q[15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[3]) amount_q[31] <= wb_dat_i[31];
        end
        `PAC_ADDR_BLOCK: begin
          if (wb_sel_i[0]) block_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) block_q[15:8] <= wb_dat_i[15:8];
        end
        `PAC_ADDR_MCOUNT: begin
          if (wb_sel_i[0]) mcount_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) mcount_q[15:8] <= wb_dat_i[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // A refused control write raises the error flag; a new refusal in the
  // same cycle as a clear keeps the flag set.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_q <= 1'b0;
    end else if (wr_en && wb_adr_i == `PAC_ADDR_CTRL &&
                 !ctrl_ok({wb_sel_i[1] ? wb_dat_i[15:8] : ctrl_q[15:8],
                           wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_q[7:0]})) begin
      err_q <= 1'b1;
    end else if (clr_err) begin
      err_q <= 1'b0;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (rd_en) begin
        case (wb_adr_i)
          `PAC_ADDR_CTRL:    wb_dat_o <= {16'h0000, ctrl_q};
          `PAC_ADDR_AMOUNT:  wb_dat_o <= {amount_q[31], 15'h0000,
                                          amount_q[`PAC_AMT_VAL]};
          `PAC_ADDR_BLOCK:   wb_dat_o <= {16'h0000, block_q};
          `PAC_ADDR_MCOUNT:  wb_dat_o <= {16'h0000, mcount_q};
          `PAC_ADDR_STATUS:  wb_dat_o <= status_word;
          `PAC_ADDR_PRESAMP: wb_dat_o <= {16'h0000, pre_q};
          default:           wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

// ----------------------------------------------------------------------------
// Trigger and arm sources
// ----------------------------------------------------------------------------
  pac_pct_conv u_conv (
    .amount   (amount_q[`PAC_AMT_VAL]),
    .unit_pct (amount_q[`PAC_AMT_UNIT]),
    .block    (block_q),
    .samples  (pre_sample_arm_level)
  );

  pac_edge_sel u_pt_edge (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .sel      (`PAC_SRC_EXT),
    .neg      (ext_arm_edge_polarity),
    .arm_source_select_a   (arm_source_select_a),
    .arm_source_select_b   (arm_source_select_b),
    .ext_arm  (ext_arm),
    .edge_hit (ext_edge)
  );

  pac_edge_sel u_arm_edge (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .sel      (arm_source_select),
    .neg      (1'b0),
    .arm_source_select_a   (arm_source_select_a),
    .arm_source_select_b   (arm_source_select_b),
    .ext_arm  (ext_arm),
    .edge_hit (arm_edge)
  );

  // Polarity matters only when the external arm input is the source.
  assign trig_ev = pretrig_source_select ? ext_edge : ti_detect;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_arm  <= 1'b0;
      stop_arm    <= 1'b0;
      delayed_arm <= 1'b0;
      sum_pair    <= `PAC_SUM_NONE;
      pre_q       <= 16'h0000;
    end else begin
      sample_arm <= arm_edge & cont_gating;
      stop_arm   <= arm_edge & ~cont_gating;
      case (delayed_arm_source)
        `PAC_SRC_A:   delayed_arm <= arm_source_select_a;
        `PAC_SRC_B:   delayed_arm <= arm_source_select_b;
        `PAC_DLY_OSC: delayed_arm <= osc_tick & cycle_sampling_arm;
        default:      delayed_arm <= 1'b0;
      endcase
      sum_pair <= ctrl_q[`PAC_CTL_SUM];
      pre_q    <= pre_sample_arm_level;
    end
  end

// ----------------------------------------------------------------------------
// Acquisition sequencer
// ----------------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    tgt_d   = tgt_q;
    mcnt_d  = mcnt_q;
    if (sample_tick && (state_q == ST_WATCH || state_q == ST_POST))
      mcnt_d = mcnt_q + 16'h0001;
    case (state_q)
      ST_IDLE, ST_DONE: begin
        if (start_cmd) begin
          cnt_d  = 16'h0000;
          mcnt_d = 16'h0000;
          if (pretrig_enable == `PAC_EN_OFF) begin
            tgt_d   = block_q;
            state_d = ST_POST;
          end else begin
            state_d = ST_ARM;
          end
        end
      end
      ST_ARM: begin
        if (block_arm) begin
          cnt_d   = 16'h0000;
          state_d = ST_WATCH;
        end
      end
      ST_WATCH: begin
        if (trig_ev) begin
          cnt_d = 16'h0000;
          if (hist_fn) begin
            state_d = ST_DONE;
          end else begin
            tgt_d   = block_q - pre_q;
            state_d = ST_POST;
          end
        end else if (pretrig_enable == `PAC_EN_COND && hist_fn &&
                     mcnt_d >= mcount_q) begin
          state_d = ST_DONE;
        end else if (sample_tick) begin
          if (cnt_q + 16'h0001 >= block_q) begin
            cnt_d = 16'h0000;
            if (pretrig_block_control)
              state_d = ST_ARM;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
      end
      ST_POST: begin
        if (tgt_q == 16'h0000) begin
          state_d = ST_DONE;
        end else if (sample_tick) begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_d >= tgt_q)
            state_d = ST_DONE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (abort_cmd)
      state_d = ST_IDLE;
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 16'h0000;
      tgt_q       <= 16'h0000;
      mcnt_q      <= 16'h0000;
      trig_seen_q <= 1'b0;
      acquire     <= 1'b0;
      pretrig_hit <= 1'b0;
      meas_done   <= 1'b0;
      block_rearm <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      tgt_q       <= tgt_d;
      mcnt_q      <= mcnt_d;
      acquire     <= state_d == ST_WATCH || state_d == ST_POST;
      pretrig_hit <= state_q == ST_WATCH && trig_ev;
      meas_done   <= state_q != ST_DONE && state_d == ST_DONE;
      block_rearm <= state_q == ST_WATCH && state_d == ST_ARM;
      // The trigger flag is set over a start in the same cycle.
      if (state_q == ST_WATCH && trig_ev)
        trig_seen_q <= 1'b1;
      else if (start_cmd)
        trig_seen_q <= 1'b0;
    end
  end

endmodule // pac_top

// >>> tb/pac_far_side.sv
module pac_far_side (
  input  wire  ref_clk,
  output wire  arm_source_select_a,
  output wire  arm_source_select_b,
  output wire  ext_arm,
  output wire  ti_detect,
  output wire  osc_tick,
  output wire  block_arm,
  output logic sample_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Channel levels, arm qualifier and sample strobe
  // --------------------------------------------------------------------------
  // Lines: 0 arm_source_select A, 1 arm_source_select B, 2 external arm, 3 detector, 4 osc, 5 arm.
  logic [5:0] lv = 6'h00;
  int         tick_per = 0;
  int         tcnt = 0;
  assign {block_arm, osc_tick, ti_detect, ext_arm, arm_source_select_b, arm_source_select_a} = lv;
  initial sample_tick = 1'b0;
  // A period of zero stops the strobe, so no sample slips into arming.
  always @(posedge ref_clk) begin
    tcnt <= (tcnt + 1 >= tick_per) ? 0 : tcnt + 1;
    sample_tick <= (tick_per != 0) && (tcnt == 0);
  end
  task automatic set_line(input int i, input logic v);
    @(posedge ref_clk);
    lv[i] <= v;
  endtask
  task automatic pulse(input int i);
    set_line(i, 1'b1);
    set_line(i, 1'b0);
  endtask
  // Launching just after a strobe keeps the event clear of sample edges.
  task automatic trig(input int i, input logic v);
    @(posedge ref_clk iff sample_tick === 1'b1);
    lv[i] <= v;
  endtask
endmodule // pac_far_side

// >>> tb/pac_top_asserts.sv
module pac_chk (
  input wire       ref_clk,
  input wire       reset_n,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire       wb_ack_o,
  input wire       arm_source_select_a,
  input wire       arm_source_select_b,
  input wire       ext_arm,
  input wire       osc_tick,
  input wire       acquire,
  input wire       pretrig_hit,
  input wire       meas_done,
  input wire       block_rearm,
  input wire       sample_arm,
  input wire       stop_arm,
  input wire       delayed_arm,
  input wire [1:0] sum_pair
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_arm_cause;
    sample_arm || stop_arm |-> !(sample_arm && stop_arm) &&
      ($past(arm_source_select_a) && !$past(arm_source_select_a, 2) || $past(arm_source_select_b) &&
       !$past(arm_source_select_b, 2) || $past(ext_arm) && !$past(ext_arm, 2));
  endproperty
  a_arm_cause: assert property (p_arm_cause)
    else $error("arm pulse without source edge");
  property p_dly;
    delayed_arm |-> $past(arm_source_select_a) || $past(arm_source_select_b) || $past(osc_tick);
  endproperty
  a_dly: assert property (p_dly)
    else $error("delayed arm without source");
  property p_hit;
    pretrig_hit |-> $past(acquire) ##1 !pretrig_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("hit outside watch");
  property p_done;
    meas_done |-> $past(acquire) && !acquire;
  endproperty
  a_done: assert property (p_done) else $error("done not ending");
  property p_rearm;
    block_rearm |-> $past(acquire) && !acquire;
  endproperty
  a_rearm: assert property (p_rearm) else $error("bad rearm");
  property p_sum_hold;
    !$stable(sum_pair) |-> $past(wb_cyc_i && wb_we_i) ||
      $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_sum_hold: assert property (p_sum_hold)
    else $error("sum pair moved without write");
  c_hit: cover property (pretrig_hit);
  c_rearm: cover property (block_rearm);
  c_sample_arm_level: cover property (sample_arm);
endmodule // pac_chk

// >>> tb/pac_top_tb.sv
`include "pac_regs.vh"

module pac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  wire  [31:0] wb_dat_o;
  wire  [1:0]  sum_pair;
  wire         wb_ack_o, acquire, pretrig_hit, meas_done, block_rearm;
  wire         sample_arm, stop_arm, delayed_arm, sample_tick;
  wire         arm_source_select_a, arm_source_select_b, ext_arm, osc_tick, ti_detect, block_arm;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n_hit, n_done, n_rearm, n_sample_arm_level, n_stop, n_dly, n_post, n_acq;
  logic        post;
  pac_top dut (.*);
  pac_far_side far (.*);
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_hit += pretrig_hit;
    n_done += meas_done;
    n_rearm += block_rearm;
    n_sample_arm_level += sample_arm;
    n_stop += stop_arm;
    n_dly += delayed_arm;
    if (pretrig_hit === 1'b1)
      post = 1'b1;
    n_post += post & sample_tick & acquire & !meas_done;
    n_acq += sample_tick & acquire & !meas_done;
  end
  // --------------------------------------------------------------------------
  // Bus and checking helpers
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    check("wb_ack", {31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input string s, input logic [7:0] a,
                    input logic [31:0] m, want);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(s, q & m, want);
  endtask
  // Counters are cleared off the sampling edge to avoid racing the monitor.
  task automatic clr;
    @(negedge ref_clk);
    {n_hit, n_done, n_rearm, n_sample_arm_level, n_stop, n_dly, n_post, n_acq} = '0;
    post = 1'b0;
  endtask
  task automatic run(input logic [31:0] ctrl);
    clr();
    wr(`PAC_ADDR_CTRL, ctrl);
    wr(`PAC_ADDR_CMD, 32'h1);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 500 && n_done == 0; i++)
      @(posedge ref_clk);
    check("meas_done", n_done, 32'h1);
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    rd("ctrl", `PAC_ADDR_CTRL, 32'hffff, 32'h0);
    rd("amount", `PAC_ADDR_AMOUNT, 32'hffffffff, 32'h80000032);
    rd("block", `PAC_ADDR_BLOCK, 32'hffff, 32'h64);
    rd("mcount", `PAC_ADDR_MCOUNT, 32'hffff, 32'h64);
    rd("presamp", `PAC_ADDR_PRESAMP, 32'hffff, 32'h32);
    rd("unit", `PAC_ADDR_STATUS, 32'h8, 32'h8);
    rd("src_ti", `PAC_ADDR_STATUS, 32'h10, 32'h0);
    rd("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_conv;
    logic [31:0] amt [4] = '{32'h80000021, 32'h800000c8, 32'h7, 32'h14};
    logic [31:0] want [4] = '{32'h3, 32'ha, 32'h7, 32'ha};
    wr(`PAC_ADDR_BLOCK, 32'ha);
    foreach (amt[i]) begin
      wr(`PAC_ADDR_AMOUNT, amt[i]);
      rd("presamp", `PAC_ADDR_PRESAMP, 32'hffff, want[i]);
      rd("unit", `PAC_ADDR_STATUS, 32'h8, {28'h0, amt[i][31], 3'h0});
    end
    $display("test conversion done");
  endtask
  task automatic t_illegal;
    logic [31:0] bad [4] = '{32'h2, 32'h100, 32'h2400, 32'h1600};
    wr(`PAC_ADDR_CTRL, 32'h3000);
    repeat (3) @(posedge ref_clk);
    check("sum_bc", {30'h0, sum_pair}, 32'h3);
    foreach (bad[i]) begin
      wr(`PAC_ADDR_CTRL, bad[i]);
      rd("ctrl_kept", `PAC_ADDR_CTRL, 32'hffff, 32'h3000);
      rd("err", `PAC_ADDR_STATUS, 32'h20, 32'h20);
      wr(`PAC_ADDR_CMD, 32'h4);
    end
    rd("err_clr", `PAC_ADDR_STATUS, 32'h20, 32'h0);
    wr(`PAC_ADDR_CTRL, 32'h1400);
    repeat (3) @(posedge ref_clk);
    check("sum_tot", {30'h0, sum_pair}, 32'h1);
    $display("test illegal settings done");
  endtask
  task automatic t_arms;
    logic [31:0] cfg [3] = '{32'h0, 32'h8020, 32'h40};
    foreach (cfg[i]) begin
      clr();
      wr(`PAC_ADDR_CTRL, cfg[i]);
      for (int k = 0; k < 3; k++)
        far.pulse(k);
      repeat (3) @(posedge ref_clk);
      check("sample_arm_level", n_sample_arm_level, {31'h0, i == 1});
      check("stop", n_stop, {31'h0, i != 1});
    end
    clr();
    wr(`PAC_ADDR_CTRL, 32'h80);
    for (int k = 0; k < 5; k = k + 2 + (k == 0))
      far.pulse(k);
    far.pulse(1);
    repeat (3) @(posedge ref_clk);
    check("dly_b", n_dly, 32'h1);
    clr();
    wr(`PAC_ADDR_CTRL, 32'h4100);
    far.pulse(4);
    repeat (3) @(posedge ref_clk);
    check("dly_osc", n_dly, 32'h1);
    $display("test arming done");
  endtask
  task automatic t_off;
    wr(`PAC_ADDR_BLOCK, 32'h8);
    wr(`PAC_ADDR_AMOUNT, 32'h80000032);
    run(32'h0);
    far.tick_per = 2;
    wait_done();
    check("off_hits", n_hit, 32'h0);
    check("off_samples", n_acq, 32'h8);
    $display("test off done");
  endtask
  task automatic t_single;
    run(32'h1);
    far.set_line(5, 1'b1);
    repeat (40) @(posedge ref_clk);
    far.set_line(5, 1'b0);
    check("watching", {31'h0, acquire}, 32'h1);
    far.trig(3, 1'b1);
    far.set_line(3, 1'b0);
    wait_done();
    check("single_rearm", n_rearm, 32'h0);
    check("post_samples", n_post, 32'h4);
    $display("test single done");
  endtask
  task automatic t_multi;
    run(32'h1d);
    far.set_line(5, 1'b1);
    repeat (40) @(posedge ref_clk);
    far.set_line(2, 1'b1);
    repeat (4) @(posedge ref_clk);
    check("rearmed", {31'h0, n_rearm != 0}, 32'h1);
    check("rise_ignored", n_hit, 32'h0);
    rd("src_ext", `PAC_ADDR_STATUS, 32'h10, 32'h10);
    // A falling edge landing in a re-arm cycle is ignored, so retry.
    repeat (4) if (n_hit == 0) begin
      far.trig(2, 1'b0);
      repeat (3) @(posedge ref_clk);
      far.set_line(2, 1'b1);
    end
    wait_done();
    far.set_line(5, 1'b0);
    $display("test repeated done");
  endtask
  task automatic t_hist;
    wr(`PAC_ADDR_MCOUNT, 32'h5);
    run(32'h601);
    far.set_line(5, 1'b1);
    repeat (10) @(posedge ref_clk);
    far.trig(3, 1'b1);
    far.set_line(3, 1'b0);
    wait_done();
    check("hist_post", n_post, 32'h0);
    far.tick_per = 0;
    run(32'h602);
    repeat (3) @(posedge ref_clk);
    far.tick_per = 2;
    wait_done();
    check("cond_hits", n_hit, 32'h0);
    check("cond_count", n_acq, 32'h5);
    $display("test histogram done");
  endtask
  // External source, rising edge: a fall must pass unnoticed, and an abort
  // must leave the sequencer idle until the next start.
  task automatic t_pos;
    run(32'h9);
    far.set_line(2, 1'b0);
    repeat (4) @(posedge ref_clk);
    check("fall_ignored", n_hit, 32'h0);
    wr(`PAC_ADDR_CMD, 32'h2);
    check("aborted", {31'h0, acquire}, 32'h0);
    wr(`PAC_ADDR_CMD, 32'h1);
    far.trig(2, 1'b1);
    wait_done();
    check("rise_hit", n_hit, 32'h1);
    check("pos_post", n_post, 32'h4);
    rd("status_end", `PAC_ADDR_STATUS, 32'h7, 32'h6);
    $display("test positive edge done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_conv();
    t_illegal();
    t_arms();
    t_off();
    t_single();
    t_multi();
    t_hist();
    t_pos();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end
endmodule // pac_top_tb

bind pac_top pac_chk chk (.*);
